// ---- rtl/ctb_pkg.sv ----
// package: constants, types and register map of the transmit buffer control block
package ctb_pkg;

	localparam int          NUM_BUF       = 16;
	localparam int          BUF_IDX_W     = 4;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;

	// register byte offsets
	localparam logic [7:0]  OFF_TX_REQUEST   = 8'h00;
	localparam logic [7:0]  OFF_ABORT_REQ    = 8'h04;
	localparam logic [7:0]  OFF_ONE_SHOT     = 8'h08;
	localparam logic [7:0]  OFF_BUF_IRQ_EN   = 8'h0c;
	localparam logic [7:0]  OFF_RESULT       = 8'h10;
	localparam logic [7:0]  OFF_CHAN_CTRL    = 8'h14;
	localparam logic [7:0]  OFF_GLB_IRQ_STS  = 8'h18;
	localparam logic [7:0]  OFF_GLB_IRQ_MASK = 8'h1c;
	localparam logic [7:0]  OFF_FIFO_LINK    = 8'h20;

	// two-bit result codes per buffer
	localparam logic [1:0]  RES_NONE      = 2'h0;
	localparam logic [1:0]  RES_ABORTED   = 2'h1;
	localparam logic [1:0]  RES_OK        = 2'h2;
	localparam logic [1:0]  RES_OK_ABTREQ = 2'h3;
	localparam int          RES_W         = 2;

	// global transmit interrupt status bit positions
	localparam int          IRQ_W         = 4;
	localparam int          IRQ_DONE      = 0;
	localparam int          IRQ_ABORT     = 1;
	localparam int          IRQ_FIFO_DONE = 2;
	localparam int          IRQ_HISTORY   = 3;

	// channel control bit position
	localparam int          CC_ABORT_IRQ_EN = 0;

	// reset values
	localparam logic [15:0] RST_BUF_VEC   = 16'h0000;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [3:0]  RST_IRQ       = 4'h0;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} ctb_state_e;

	// register port request
	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
	} ctb_reg_req_s;

	// outcome of a frame from the protocol engine, one-cycle pulses
	typedef struct packed {
		logic                  ok;
		logic                  arb_lost;
		logic                  err;
	} ctb_eng_evt_s;

endpackage : ctb_pkg

// ---- rtl/ctb_tx_buffer_control.sv ----
// transmit buffer control for one CAN channel: requests, aborts, one-shot, results, interrupt
//
// What this block does
// - sixteen buffers, standalone or linked to FIFO
// - request write sets pending of standalone buffers, starts transmission
// - success without abort gives result 10
// - success with abort requested gives 11
// - per-buffer completion interrupt enable bit
// - abort write cancels a pending request
// - active or next buffer aborts on loss/error
// - other pending buffers abort at once
// - abort done: result 01, pending cleared
// - abort requested but sent reports 11
// - without one-shot, retry after lost arbitration
// - one-shot attempts once, never retries
// - one-shot loss or error gives 01
// - enabled completion raises channel transmit interrupt if its global mask bit is set
// - four interrupt sources with readable flags
// - channel abort interrupt enable bit
// - sent-despite-abort signals completion, not abort
`timescale 1ns/1ps

module ctb_tx_buffer_control #(
	parameter int NBUF = ctb_pkg::NUM_BUF  // number of transmit buffers
) (
	input  wire logic                           core_clk_i,  // 20 MHz core clock
	input  wire logic                           reset_i,     // synchronous reset, high
	input  wire ctb_pkg::ctb_reg_req_s          bus_i,       // register port request
	output logic [ctb_pkg::DATA_W-1:0]          rdata_o,     // read data, cycle after read
	input  wire ctb_pkg::ctb_eng_evt_s          eng_evt_i,   // frame outcome pulses
	input  wire logic                           eng_take_i,  // engine starts offered frame
	output logic                                eng_req_o,   // a buffer is offered
	output logic [ctb_pkg::BUF_IDX_W-1:0]       eng_buf_o,   // offered buffer index
	input  wire logic [NBUF-1:0]                fifo_req_i,  // FIFO requests for linked buffers
	input  wire logic                           fifo_done_i, // FIFO completion event
	input  wire logic                           hist_i,      // transmit history event
	output logic [NBUF-1:0]                     fifo_sent_o, // linked buffer sent, pulse
	output logic                                irq_o        // channel transmit interrupt
);
	import ctb_pkg::*;

	ctb_state_e                 state;
	ctb_state_e                 next_state;
	logic [BUF_IDX_W-1:0]       cur_buf;
	logic [NBUF-1:0]            pending;
	logic [NBUF-1:0]            next_pending;
	logic [NBUF-1:0]            abort_q;
	logic [NBUF-1:0]            next_abort;
	logic [NBUF-1:0]            one_shot_mode;
	logic [NBUF-1:0]            buf_done_irq_en;
	logic [NBUF-1:0]            fifo_link;
	logic [NBUF*RES_W-1:0]      tx_result_code;
	logic [NBUF*RES_W-1:0]      next_result;
	logic                       abort_irq_en;
	logic [IRQ_W-1:0]           irq_sts;
	logic [IRQ_W-1:0]           irq_mask;
	logic [IRQ_W-1:0]           irq_evt;

	logic [NBUF-1:0]            req_set;
	logic [NBUF-1:0]            abt_set;
	logic [NBUF*RES_W-1:0]      res_clr;
	logic [NBUF-1:0]            ok_vec;
	logic [NBUF-1:0]            abort_vec;
	logic                       any_fail;
	logic                       next_req;
	logic [BUF_IDX_W-1:0]       next_buf;
	logic [DATA_W-1:0]          rd_mux;
	logic                       second_vld;
	logic [BUF_IDX_W-1:0]       second_buf;

	logic                       wr_txreq;
	logic                       wr_abort;
	logic                       wr_oneshot;
	logic                       wr_bufirq;
	logic                       wr_result;
	logic                       wr_chan;
	logic                       wr_sts;
	logic                       wr_mask;
	logic                       wr_link;

	assign wr_txreq   = bus_i.wr && (bus_i.addr == OFF_TX_REQUEST);
	assign wr_abort   = bus_i.wr && (bus_i.addr == OFF_ABORT_REQ);
	assign wr_oneshot = bus_i.wr && (bus_i.addr == OFF_ONE_SHOT);
	assign wr_bufirq  = bus_i.wr && (bus_i.addr == OFF_BUF_IRQ_EN);
	assign wr_result  = bus_i.wr && (bus_i.addr == OFF_RESULT);
	assign wr_chan    = bus_i.wr && (bus_i.addr == OFF_CHAN_CTRL);
	assign wr_sts     = bus_i.wr && (bus_i.addr == OFF_GLB_IRQ_STS);
	assign wr_mask    = bus_i.wr && (bus_i.addr == OFF_GLB_IRQ_MASK);
	assign wr_link    = bus_i.wr && (bus_i.addr == OFF_FIFO_LINK);

	// standalone buffers take software requests, linked ones take FIFO requests
	assign req_set = ((wr_txreq ? bus_i.wdata[NBUF-1:0] : RST_BUF_VEC[NBUF-1:0]) & ~fifo_link)
		| (fifo_req_i & fifo_link);
	assign abt_set = wr_abort ? bus_i.wdata[NBUF-1:0] : RST_BUF_VEC[NBUF-1:0];
	assign res_clr = wr_result ? bus_i.wdata[NBUF*RES_W-1:0] : RST_WORD[NBUF*RES_W-1:0];
	assign any_fail = eng_evt_i.arb_lost | eng_evt_i.err;

	// next in line behind the frame on the bus, it must also wait for loss or error
	always_comb
	begin
		second_vld = 1'b0;
		second_buf = '0;
		for (int i = NBUF - 1; i >= 0; i--)
		begin
			if (pending[i] && !((state == ST_BUSY) && (cur_buf == BUF_IDX_W'(i))))
			begin
				second_vld = 1'b1;
				second_buf = BUF_IDX_W'(i);
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NBUF; gi++)
		begin : g_buf
			logic cur_hit;
			logic offered;
			logic ok_hit;
			logic give_up;
			logic imm_abt;
			logic ending;
			logic queued;
			logic [RES_W-1:0] res_nx;

			assign cur_hit = (state == ST_BUSY) && (cur_buf == BUF_IDX_W'(gi));
			assign queued  = (state == ST_BUSY) && second_vld
				&& (second_buf == BUF_IDX_W'(gi));
			assign offered = (state == ST_IDLE) && eng_req_o && (eng_buf_o == BUF_IDX_W'(gi));
			assign ok_hit  = eng_evt_i.ok & cur_hit;
			// failed attempt ends the request only for one-shot or abort-requested buffers
			assign give_up = any_fail & cur_hit
				& (one_shot_mode[gi] | abort_q[gi] | abt_set[gi]);
			// buffers neither on the bus nor next in line are dropped right away
			assign imm_abt = abt_set[gi] & pending[gi] & ~cur_hit & ~offered
				& ~queued;
			assign ending  = ok_hit | give_up | imm_abt;

			assign ok_vec[gi]    = ok_hit;
			assign abort_vec[gi] = give_up | imm_abt;

			// a fresh request wins over a completion in the same cycle
			assign next_pending[gi] = req_set[gi] ? 1'b1
				: (ending ? 1'b0 : pending[gi]);
			assign next_abort[gi] = ending ? 1'b0
				: (abort_q[gi] | (abt_set[gi] & pending[gi]));

			always_comb
			begin
				res_nx = tx_result_code[gi*RES_W +: RES_W]
					& ~res_clr[gi*RES_W +: RES_W];
				if (ok_hit)
				begin
					res_nx = (abort_q[gi] | abt_set[gi])
						? RES_OK_ABTREQ : RES_OK;
				end
				else if (give_up | imm_abt)
				begin
					res_nx = RES_ABORTED;
				end
			end
			assign next_result[gi*RES_W +: RES_W] = res_nx;
		end
	endgenerate

	// lowest index wins among pending buffers
	always_comb
	begin
		next_req = 1'b0;
		next_buf = '0;
		for (int i = NBUF - 1; i >= 0; i--)
		begin
			if (next_pending[i])
			begin
				next_req = 1'b1;
				next_buf = BUF_IDX_W'(i);
			end
		end
	end

	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_IDLE:
			begin
				if (eng_take_i && eng_req_o)
				begin
					next_state = ST_BUSY;
				end
			end
			ST_BUSY:
			begin
				if (eng_evt_i.ok || any_fail)
				begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			state   <= ST_IDLE;
			cur_buf <= '0;
		end
		else
		begin
			state <= next_state;
			if (state == ST_IDLE && eng_take_i && eng_req_o)
			begin
				cur_buf <= eng_buf_o;
			end
		end
	end

	// offer is withheld while a frame is on the bus; a lost frame is re-offered
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			eng_req_o <= 1'b0;
			eng_buf_o <= '0;
		end
		else
		begin
			eng_req_o <= next_req && (next_state == ST_IDLE);
			eng_buf_o <= next_buf;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			pending        <= RST_BUF_VEC[NBUF-1:0];
			abort_q        <= RST_BUF_VEC[NBUF-1:0];
			tx_result_code <= RST_WORD[NBUF*RES_W-1:0];
		end
		else
		begin
			pending        <= next_pending;
			abort_q        <= next_abort;
			tx_result_code <= next_result;
		end
	end

	// configuration registers
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			one_shot_mode   <= RST_BUF_VEC[NBUF-1:0];
			buf_done_irq_en <= RST_BUF_VEC[NBUF-1:0];
			fifo_link       <= RST_BUF_VEC[NBUF-1:0];
			abort_irq_en    <= 1'b0;
			irq_mask        <= RST_IRQ;
		end
		else
		begin
			if (wr_oneshot)
			begin
				one_shot_mode <= bus_i.wdata[NBUF-1:0];
			end
			if (wr_bufirq)
			begin
				buf_done_irq_en <= bus_i.wdata[NBUF-1:0];
			end
			if (wr_link)
			begin
				fifo_link <= bus_i.wdata[NBUF-1:0];
			end
			if (wr_chan)
			begin
				abort_irq_en <= bus_i.wdata[CC_ABORT_IRQ_EN];
			end
			if (wr_mask)
			begin
				irq_mask <= bus_i.wdata[IRQ_W-1:0];
			end
		end
	end

	// a sent-despite-abort frame lands in ok_vec, so it counts as completion only
	assign irq_evt[IRQ_DONE]      = |(ok_vec & buf_done_irq_en & ~fifo_link);
	assign irq_evt[IRQ_ABORT]     = (|abort_vec) & abort_irq_en;
	assign irq_evt[IRQ_FIFO_DONE] = (|(ok_vec & fifo_link)) | fifo_done_i;
	assign irq_evt[IRQ_HISTORY]   = hist_i;

	// sticky flags, write one to clear, a new event wins over the clear
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			irq_sts <= RST_IRQ;
			irq_o   <= 1'b0;
		end
		else
		begin
			irq_sts <= (irq_sts & ~(wr_sts ? bus_i.wdata[IRQ_W-1:0] : RST_IRQ))
				| irq_evt;
			irq_o   <= |(irq_sts & irq_mask);
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			fifo_sent_o <= RST_BUF_VEC[NBUF-1:0];
		end
		else
		begin
			fifo_sent_o <= ok_vec & fifo_link;
		end
	end

	always_comb
	begin
		rd_mux = RST_WORD;
		unique case (bus_i.addr)
			OFF_TX_REQUEST:   rd_mux[NBUF-1:0] = pending;
			OFF_ABORT_REQ:    rd_mux[NBUF-1:0] = abort_q;
			OFF_ONE_SHOT:     rd_mux[NBUF-1:0] = one_shot_mode;
			OFF_BUF_IRQ_EN:   rd_mux[NBUF-1:0] = buf_done_irq_en;
			OFF_RESULT:       rd_mux[NBUF*RES_W-1:0] = tx_result_code;
			OFF_CHAN_CTRL:    rd_mux[CC_ABORT_IRQ_EN] = abort_irq_en;
			OFF_GLB_IRQ_STS:  rd_mux[IRQ_W-1:0] = irq_sts;
			OFF_GLB_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask;
			OFF_FIFO_LINK:    rd_mux[NBUF-1:0] = fifo_link;
			default:          rd_mux = RST_WORD;
		endcase
	end

	// read data stand only in the cycle after the read strobe
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			rdata_o <= RST_WORD;
		end
		else
		begin
			rdata_o <= bus_i.rd ? rd_mux : RST_WORD;
		end
	end

endmodule // ctb_tx_buffer_control

// ---- verification/ctb_tx_buffer_control_assertions.sv ----
// checker: port-level properties of the transmit buffer control
`timescale 1ns/1ps
module ctb_tx_buffer_control_assertions #(
	parameter int NBUF = 16	// buffers
) (
	input wire logic	core_clk_i,	// clock
	input wire logic	reset_i,	// reset
	input wire ctb_pkg::ctb_reg_req_s	bus_i,	// register request
	input wire logic [ctb_pkg::DATA_W-1:0]	rdata_o,	// read data
	input wire ctb_pkg::ctb_eng_evt_s	eng_evt_i,	// frame outcome
	input wire logic	eng_take_i,	// take pulse
	input wire logic	eng_req_o,	// offer
	input wire logic [ctb_pkg::BUF_IDX_W-1:0]	eng_buf_o,	// offered index
	input wire logic [NBUF-1:0]	fifo_req_i,	// fifo requests
	input wire logic	fifo_done_i,	// fifo event
	input wire logic	hist_i,	// history event
	input wire logic [NBUF-1:0]	fifo_sent_o,	// linked sent
	input wire logic	irq_o	// interrupt
);
	import ctb_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	logic	busy;
	logic	src;
	logic	ok_e;
	assign src = |eng_evt_i || fifo_done_i || hist_i || bus_i.wr;
	assign ok_e = eng_evt_i.ok;
	// frame on the bus between an honoured take and its outcome
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			busy <= 1'b0;
		else if (eng_req_o && eng_take_i)
			busy <= 1'b1;
		else if (|eng_evt_i)
			busy <= 1'b0;
	end
	a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == '0)
		else $error("read data outside read slot");
	a_unmapped_read: assert property (bus_i.rd && bus_i.addr == 8'h3c |=> rdata_o == '0)
		else $error("unmapped read not zero");
	a_take_drops: assert property (eng_req_o && eng_take_i |=> !eng_req_o)
		else $error("offer kept after take");
	a_quiet_busy: assert property (busy |-> !eng_req_o)
		else $error("offer during frame");
	a_offer_holds: assert property (eng_req_o && !eng_take_i && !bus_i.wr && fifo_req_i == '0
		|=> eng_req_o && $stable(eng_buf_o))
		else $error("offer changed without cause");
	a_irq_cause: assert property ($rose(irq_o) |-> $past(src, 2) || $past(bus_i.wr, 3))
		else $error("interrupt without event");
	a_irq_hold: assert property (irq_o && !bus_i.wr && !$past(bus_i.wr) |=> irq_o)
		else $error("interrupt dropped without clear");
	a_sent_pulse: assert property (fifo_sent_o != '0 |-> ($past(ok_e) || $past(ok_e, 2))
		##1 fifo_sent_o == '0)
		else $error("linked sent pulse wrong");
	a_sent_onehot: assert property ($onehot0(fifo_sent_o))
		else $error("several linked buffers sent");
	c_lost: cover property (eng_evt_i.arb_lost);
	c_sent: cover property (fifo_sent_o != '0);
	c_irq: cover property ($rose(irq_o));
endmodule // ctb_tx_buffer_control_assertions

// ---- verification/ctb_node_model.sv ----
// partner: other nodes deciding the outcome of each offered frame
`timescale 1ns/1ps
module ctb_node_model (
	input wire logic	clk_i,	// clock
	input wire logic	rst_i,	// reset
	input wire logic	req_i,	// frame offered
	input wire logic	hold_i,	// stall, no take
	input wire logic	err_i,	// failed attempt is an error
	input wire logic [3:0]	dly_i,	// frame length
	input wire logic [7:0]	nbad_i,	// attempts up to this fail
	output logic	take_o,	// start pulse
	output ctb_pkg::ctb_eng_evt_s	evt_o,	// outcome pulse
	output logic	busy_o,	// frame on bus
	output logic [7:0]	n_take_o	// attempts so far
);
	import ctb_pkg::*;
	logic [3:0]	cnt;
	logic	bad;
	assign bad = n_take_o <= nbad_i;
	always_ff @(posedge clk_i)
	begin
		take_o <= 1'b0;
		evt_o <= '0;
		if (rst_i)
		begin
			busy_o <= 1'b0;
			cnt <= 4'h0;
			n_take_o <= 8'h00;
		end
		else if (take_o)
		begin
			busy_o <= 1'b1;
			cnt <= dly_i;
			n_take_o <= n_take_o + 8'h01;
		end
		else if (busy_o && cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else if (busy_o)
		begin
			busy_o <= 1'b0;
			evt_o <= '{!bad, bad && !err_i, bad && err_i};
		end
		else if (req_i && !hold_i)
			take_o <= 1'b1;
	end
endmodule // ctb_node_model

// ---- verification/testbench.sv ----
// testbench: register-level scenarios for the transmit buffer control
`timescale 1ns/1ps
module testbench;
	import ctb_pkg::*;
	logic	clk = 1'b0;
	logic	rst = 1'b1;
	ctb_reg_req_s	bus = '0;
	ctb_eng_evt_s	evt;
	logic [31:0]	rdata;
	logic	take, ereq, busy, irq, hold = 1'b0, err = 1'b0;
	logic	fdone = 1'b0, hist = 1'b0;
	logic [3:0]	ebuf, dly = 4'h2;
	logic [7:0]	ntake, base, nbad = 8'h00;
	logic [15:0]	sent, freq = '0, seen = '0;
	int	n_fail = 0, cmp_count = 0;
	ctb_tx_buffer_control i_dut (.core_clk_i(clk), .reset_i(rst), .bus_i(bus),
		.rdata_o(rdata), .eng_evt_i(evt), .eng_take_i(take), .eng_req_o(ereq),
		.eng_buf_o(ebuf), .fifo_req_i(freq), .fifo_done_i(fdone), .hist_i(hist),
		.fifo_sent_o(sent), .irq_o(irq));
	ctb_node_model i_node (.clk_i(clk), .rst_i(rst), .req_i(ereq), .hold_i(hold),
		.err_i(err), .dly_i(dly), .nbad_i(nbad), .take_o(take), .evt_o(evt),
		.busy_o(busy), .n_take_o(ntake));
	initial
		forever #25 clk = ~clk;
	always @(posedge clk)
		seen <= rst ? '0 : (seen | sent);
	task automatic chk(input string n, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk);
		bus <= '0;
		@(negedge clk);
		chk($sformatf("reg %h", a), e, rdata);
		@(posedge clk);
	endtask
	task automatic irq_is(input logic e);
		@(negedge clk);
		chk("irq", 32'(e), 32'(irq));
		@(posedge clk);
	endtask
	// wait until no offer, take or frame for four cycles
	task automatic settle;
		int q;
		q = 0;
		for (int k = 0; k < 300 && q < 4; k++)
		begin
			@(posedge clk);
			q = (busy || ereq || take) ? 0 : q + 1;
		end
		chk("settle", 32'h1, 32'(q >= 4));
	endtask
	task automatic send(input logic [31:0] d);
		wr(OFF_TX_REQUEST, d);
		settle;
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		conclude;
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int a = 0; a <= 32; a += 4)
			rd(a[7:0], 32'h0);
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c, 32'h0);
		wr(OFF_CHAN_CTRL, 32'h1);
		wr(OFF_GLB_IRQ_MASK, 32'hf);
		send(32'h8000);
		rd(OFF_RESULT, 32'h8000_0000);
		rd(OFF_GLB_IRQ_STS, 32'h0);
		wr(OFF_RESULT, 32'hc000_0000);
		wr(OFF_BUF_IRQ_EN, 32'hffff);
		wr(OFF_GLB_IRQ_MASK, 32'h0);
		send(32'h8000);
		rd(OFF_GLB_IRQ_STS, 32'h1);
		irq_is(1'b0);
		wr(OFF_GLB_IRQ_MASK, 32'hf);
		irq_is(1'b1);
		wr(OFF_GLB_IRQ_STS, 32'hf);
		irq_is(1'b0);
		hold <= 1'b1;
		wr(OFF_TX_REQUEST, 32'h9);
		wr(OFF_ABORT_REQ, 32'h8);
		rd(OFF_RESULT, 32'h8000_0040);
		rd(OFF_TX_REQUEST, 32'h1);
		rd(OFF_GLB_IRQ_STS, 32'h2);
		wr(OFF_ABORT_REQ, 32'h1);
		rd(OFF_TX_REQUEST, 32'h1);
		nbad <= ntake + 8'h01;
		hold <= 1'b0;
		settle;
		rd(OFF_RESULT, 32'h8000_0041);
		wr(OFF_RESULT, 32'hffff_ffff);
		wr(OFF_GLB_IRQ_STS, 32'hf);
		dly <= 4'h8;
		nbad <= ntake;
		wr(OFF_TX_REQUEST, 32'h14);
		for (int k = 0; k < 50 && !busy; k++)
			@(posedge clk);
		wr(OFF_ABORT_REQ, 32'h14);
		rd(OFF_TX_REQUEST, 32'h14);
		settle;
		rd(OFF_RESULT, 32'h330);
		rd(OFF_GLB_IRQ_STS, 32'h1);
		wr(OFF_RESULT, 32'h330);
		rd(OFF_RESULT, 32'h0);
		dly <= 4'h2;
		base = ntake;
		nbad <= ntake + 8'h02;
		send(32'h20);
		rd(OFF_RESULT, 32'h800);
		chk("tries", 32'(base + 8'h03), 32'(ntake));
		wr(OFF_ONE_SHOT, 32'h40);
		base = ntake;
		nbad <= ntake + 8'h01;
		err <= 1'b1;
		send(32'h40);
		rd(OFF_RESULT, 32'h1800);
		chk("tries", 32'(base + 8'h01), 32'(ntake));
		wr(OFF_GLB_IRQ_STS, 32'hf);
		wr(OFF_FIFO_LINK, 32'h100);
		freq <= 16'h100;
		@(posedge clk);
		freq <= '0;
		settle;
		chk("sent", 32'h100, 32'(seen));
		fdone <= 1'b1;
		hist <= 1'b1;
		@(posedge clk);
		fdone <= 1'b0;
		hist <= 1'b0;
		@(posedge clk);
		rd(OFF_GLB_IRQ_STS, 32'hc);
		conclude;
	end
endmodule // testbench
bind ctb_tx_buffer_control ctb_tx_buffer_control_assertions #(.NBUF(NBUF)) i_chk (
	.core_clk_i(core_clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
	.eng_evt_i(eng_evt_i), .eng_take_i(eng_take_i), .eng_req_o(eng_req_o),
	.eng_buf_o(eng_buf_o), .fifo_req_i(fifo_req_i), .fifo_done_i(fifo_done_i),
	.hist_i(hist_i), .fifo_sent_o(fifo_sent_o), .irq_o(irq_o));
